// >>> logic/adcsl_pkg.sv
// Shared constants and types of the converter selection latch block
`default_nettype none
package adcsl_pkg;
   localparam int unsigned ADCSL_RES_BITS   = 10;
   localparam int unsigned ADCSL_NORMAL_CYC = 13;
   localparam int unsigned ADCSL_FIRST_CYC  = 25;
   localparam int unsigned ADCSL_CNT_W      = 5;
   localparam logic [ADCSL_RES_BITS-1:0] ADCSL_CODE_ZERO  = 10'h000;
   localparam logic [ADCSL_RES_BITS-1:0] ADCSL_CODE_MSB   = 10'h200;
   localparam logic [ADCSL_RES_BITS-1:0] ADCSL_FULL_SCALE = 10'h3FF;
   localparam logic [ADCSL_CNT_W-1:0]    ADCSL_CNT_ZERO   = 5'h00;

   typedef struct packed {
      logic [1:0] reference_select;
      logic [4:0] channel_select;
   } adcsl_sel_t;

   localparam adcsl_sel_t ADCSL_SEL_RST = 7'h00;

   typedef struct packed {
      logic converter_enable;
      logic auto_trigger_enable;
      logic free_running;
      logic irq_enable;
   } adcsl_ctrl_t;

   typedef enum logic [2:0] {
      ADCSL_SLP_IDLE  = 3'h1,
      ADCSL_SLP_NOISE = 3'h2,
      ADCSL_SLP_OTHER = 3'h4
   } adcsl_sleep_t;

   typedef enum logic [1:0] {
      ADCSL_SAR_IDLE = 2'h1,
      ADCSL_SAR_CONV = 2'h2
   } adcsl_sar_st_t;
endpackage
`default_nettype wire

// >>> logic/adcsl_sar.sv
// Successive approximation sequencer counting converter clock ticks
`default_nettype none
`timescale 1ns/1ps
module adcsl_sar
   import adcsl_pkg::*;
(
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // Control
   input  wire logic                      adc_tick,
   input  wire logic                      start,
   input  wire logic                      first_conv,
   input  wire logic                      abort,
   input  wire logic                      cmp_hi,
   // Status and data
   output logic                           busy,
   output logic                           last_cycle,
   output logic                           done,
   output logic [ADCSL_RES_BITS-1:0]      trial,
   output logic [ADCSL_RES_BITS-1:0]      result
);
   adcsl_sar_st_t               state_r, state_nxt;
   logic [ADCSL_CNT_W-1:0]      cnt_r, cnt_nxt, total;
   logic [ADCSL_RES_BITS-1:0]   code_r, code_nxt, mask_r, mask_nxt, res_r, res_nxt;
   logic                        first_r, first_nxt;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      code_nxt  = code_r;
      mask_nxt  = mask_r;
      res_nxt   = res_r;
      first_nxt = first_r;
      done      = 1'b0;
      total     = first_r ? ADCSL_CNT_W'(ADCSL_FIRST_CYC) : ADCSL_CNT_W'(ADCSL_NORMAL_CYC);
      unique case (state_r)
         ADCSL_SAR_IDLE:
            if (adc_tick && start && !abort)
            begin
               state_nxt = ADCSL_SAR_CONV;
               cnt_nxt   = ADCSL_CNT_ZERO;
               code_nxt  = ADCSL_CODE_MSB;
               mask_nxt  = ADCSL_CODE_MSB;
               first_nxt = first_conv;
            end
         ADCSL_SAR_CONV:
            if (abort)
               state_nxt = ADCSL_SAR_IDLE;
            else if (adc_tick)
            begin
               if (cnt_r == total - 5'h01)
               begin
                  done    = 1'b1;
                  res_nxt = code_r;
                  if (start)
                  begin
                     cnt_nxt   = ADCSL_CNT_ZERO;
                     code_nxt  = ADCSL_CODE_MSB;
                     mask_nxt  = ADCSL_CODE_MSB;
                     first_nxt = 1'b0;
                  end
                  else
                     state_nxt = ADCSL_SAR_IDLE;
               end
               else
               begin
                  cnt_nxt = cnt_r + 5'h01;
                  // Bits settle in the ten cycles before the final one
                  if (mask_r != ADCSL_CODE_ZERO && cnt_r >= total - 5'h0B)
                  begin
                     // Input above every trial resolves to full scale
                     code_nxt = (cmp_hi ? code_r : (code_r & ~mask_r)) | (mask_r >> 1);
                     mask_nxt = mask_r >> 1;
                  end
               end
            end
         default:
            state_nxt = ADCSL_SAR_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ADCSL_SAR_IDLE;
         cnt_r   <= ADCSL_CNT_ZERO;
         code_r  <= ADCSL_CODE_ZERO;
         mask_r  <= ADCSL_CODE_ZERO;
         res_r   <= ADCSL_CODE_ZERO;
         first_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         code_r  <= code_nxt;
         mask_r  <= mask_nxt;
         res_r   <= res_nxt;
         first_r <= first_nxt;
      end
   end

   assign busy       = (state_r == ADCSL_SAR_CONV);
   assign last_cycle = busy && (cnt_r == total - 5'h01);
   assign trial      = code_r;
   assign result     = res_r;
endmodule
`default_nettype wire

// >>> logic/adcsl_ctrl.sv
// Converter selection latch, start control and sleep-triggered start
`default_nettype none
`timescale 1ns/1ps
module adcsl_ctrl
   import adcsl_pkg::*;
(
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // Selection buffer access
   input  wire logic                      sel_wr,
   input  wire adcsl_sel_t                sel_wdata,
   output adcsl_sel_t                     sel_rdata,
   output adcsl_sel_t                     sel_active,
   // Control
   input  wire adcsl_ctrl_t               ctrl,
   input  wire logic                      start_wr,
   input  wire logic                      done_clr,
   input  wire logic                      trigger_in,
   input  wire logic                      adc_tick,
   // CPU sleep
   input  wire logic                      cpu_halt,
   input  wire adcsl_sleep_t              sleep_mode,
   // Analog side
   input  wire logic                      cmp_in,
   output logic [ADCSL_RES_BITS-1:0]      dac_code,
   output logic                           analog_power_on,
   // Status
   output logic                           prescaler_reset,
   output logic                           start_bit,
   output logic                           done_flag,
   output logic [ADCSL_RES_BITS-1:0]      result,
   output logic                           irq_req,
   output logic                           sleep_conv
);
   adcsl_sel_t  sel_buf_r, sel_buf_nxt, sel_lat_r, sel_lat_nxt;
   logic        cmp_s1_r, cmp_s2_r;
   logic        trig_d_r, pend_r, pend_nxt, first_r, first_nxt;
   logic        done_r, done_nxt, slp_r, slp_nxt;
   logic        sar_busy, sar_last, sar_done, sar_start, accept;
   logic        active, trig_go, sleep_go, free_run, user_go;

   adcsl_sar u_sar (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .adc_tick   (adc_tick),
      .start      (sar_start),
      .first_conv (first_r),
      .abort      (!ctrl.converter_enable),
      .cmp_hi     (cmp_s2_r),
      .busy       (sar_busy),
      .last_cycle (sar_last),
      .done       (sar_done),
      .trial      (dac_code),
      .result     (result)
   );

   assign active   = pend_r || sar_busy;
   assign free_run = ctrl.converter_enable && ctrl.auto_trigger_enable && ctrl.free_running;
   // Edges arriving during a conversion are dropped
   assign trig_go  = ctrl.converter_enable && ctrl.auto_trigger_enable && !ctrl.free_running
                     && trigger_in && !trig_d_r && !active;
   assign user_go  = start_wr && ctrl.converter_enable && !active;
   // Only a halt event starts; staying asleep or awake never retriggers
   assign sleep_go = cpu_halt && (sleep_mode == ADCSL_SLP_IDLE || sleep_mode == ADCSL_SLP_NOISE)
                     && ctrl.converter_enable && !ctrl.auto_trigger_enable && !active;
   assign sar_start = pend_r || (sar_done && free_run);
   assign accept    = adc_tick && pend_r && !sar_busy && ctrl.converter_enable;

   always_comb
   begin
      sel_buf_nxt = sel_wr ? sel_wdata : sel_buf_r;
      // Open while idle and in the final cycle, shut otherwise for every start source
      sel_lat_nxt = (!sar_busy || sar_last) ? sel_buf_r : sel_lat_r;
      pend_nxt    = pend_r;
      if (user_go || trig_go || sleep_go)
         pend_nxt = 1'b1;
      if (accept || !ctrl.converter_enable)
         pend_nxt = 1'b0;
      first_nxt   = first_r;
      if (!ctrl.converter_enable)
         first_nxt = 1'b1;
      else if (accept)
         first_nxt = 1'b0;
      // Completion wins over a clear in the same cycle
      done_nxt    = sar_done || (done_r && !done_clr);
      slp_nxt     = slp_r;
      if (sleep_go)
         slp_nxt = 1'b1;
      else if (sar_done || !ctrl.converter_enable)
         slp_nxt = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_buf_r <= ADCSL_SEL_RST;
         sel_lat_r <= ADCSL_SEL_RST;
         cmp_s1_r  <= 1'b0;
         cmp_s2_r  <= 1'b0;
         trig_d_r  <= 1'b0;
         pend_r    <= 1'b0;
         first_r   <= 1'b1;
         done_r    <= 1'b0;
         slp_r     <= 1'b0;
      end
      else
      begin
         sel_buf_r <= sel_buf_nxt;
         sel_lat_r <= sel_lat_nxt;
         cmp_s1_r  <= cmp_in;
         cmp_s2_r  <= cmp_s1_r;
         trig_d_r  <= trigger_in;
         pend_r    <= pend_nxt;
         first_r   <= first_nxt;
         done_r    <= done_nxt;
         slp_r     <= slp_nxt;
      end
   end

   assign sel_rdata       = sel_buf_r;
   assign sel_active      = sel_lat_r;
   assign prescaler_reset = trig_go;
   assign start_bit       = active;
   assign done_flag       = done_r;
   // Request stands until cleared, so an earlier wake cannot lose it
   assign irq_req         = done_r && ctrl.irq_enable;
   assign sleep_conv      = slp_r;
   // Sleep mode does not gate power; software must drop the enable
   assign analog_power_on = ctrl.converter_enable;

   a_idle_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !sar_busy |=> sel_lat_r == $past(sel_buf_r))
      else $error("latch did not follow buffer while idle");
   a_lock_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sar_busy && !sar_last && ctrl.converter_enable) ##1 sar_busy |-> $stable(sel_lat_r))
      else $error("latch changed during conversion");
   a_reopen_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sar_last |=> sel_lat_r == $past(sel_buf_r))
      else $error("latch not reopened in final cycle");
   a_start_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
      accept |=> sar_busy && !pend_r)
      else $error("conversion did not begin on tick");
   a_start_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (user_go ##1 !(accept || !ctrl.converter_enable)) |-> start_bit)
      else $error("start bit low with conversion pending");
   a_done_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sar_done |=> done_flag && result == $past(dac_code))
      else $error("completion did not set flag and result");
   a_free_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sar_done && free_run) |=> sar_busy && start_bit)
      else $error("free-running restart missing");
   a_sleep_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sleep_go |=> pend_r && sleep_conv)
      else $error("sleep entry did not request conversion");
   a_sleep_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cpu_halt && sar_busy) |-> !sleep_go)
      else $error("sleep start during conversion");
   a_irq_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sar_done && ctrl.irq_enable) ##1 ctrl.irq_enable |-> irq_req)
      else $error("completion request not raised");
   a_trig_presc: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (trigger_in && !trig_d_r && ctrl.converter_enable && ctrl.auto_trigger_enable
       && !ctrl.free_running && !active) |-> prescaler_reset ##1 pend_r)
      else $error("trigger edge did not start conversion");

   // Buffer, flag, sleep and trigger bookkeeping
   a_buf_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sel_wr |=> sel_rdata == $past(sel_wdata))
      else $error("buffer write not taken");
   a_buf_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !sel_wr |=> $stable(sel_rdata))
      else $error("buffer changed without a write");
   a_done_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (done_clr && !sar_done) |=> !done_flag)
      else $error("done flag not cleared");
   a_start_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sar_done && !free_run) |=> !start_bit)
      else $error("start bit not cleared at completion");
   a_sleep_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sar_done |=> !sleep_conv)
      else $error("sleep conversion flag stuck");
   a_irq_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (irq_req && !done_clr) ##1 ctrl.irq_enable |-> irq_req)
      else $error("completion request dropped");
   a_other_sleep: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cpu_halt && sleep_mode == ADCSL_SLP_OTHER) |-> !sleep_go && analog_power_on == ctrl.converter_enable)
      else $error("other sleep mode touched the converter");
   a_trig_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
      active |-> !prescaler_reset)
      else $error("trigger edge accepted while busy");

   // Main scenarios the bench is expected to reach
   c_sleep_conv: cover property (@(posedge sys_clk) disable iff (!rst_n) sleep_conv && sar_done);
   c_free_run:   cover property (@(posedge sys_clk) disable iff (!rst_n) sar_done && free_run);
   c_wr_locked:  cover property (@(posedge sys_clk) disable iff (!rst_n) sel_wr && sar_busy && !sar_last);
   c_trig_start: cover property (@(posedge sys_clk) disable iff (!rst_n) prescaler_reset ##1 pend_r);
   c_sleep_busy: cover property (@(posedge sys_clk) disable iff (!rst_n) cpu_halt && active);
endmodule
`default_nettype wire

// >>> testbench/adcsl_cpu_model.sv
// CPU core model: sleep entry with halt pulse, wake-up by interrupt
`default_nettype none
`timescale 1ns/1ps
module adcsl_cpu_model
   import adcsl_pkg::*;
(
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   // Bench commands
   input  wire logic          go_sleep,
   input  wire adcsl_sleep_t  mode,
   input  wire logic          ext_wake,
   // Converter side
   input  wire logic          irq_req,
   output logic               cpu_halt,
   output adcsl_sleep_t       sleep_mode,
   output logic               asleep
);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cpu_halt   <= 1'b0;
         sleep_mode <= ADCSL_SLP_OTHER;
         asleep     <= 1'b0;
      end
      else
      begin
         cpu_halt   <= go_sleep;
         // Mode is only valid with the halt pulse, so show another one elsewhere
         sleep_mode <= go_sleep ? mode : ADCSL_SLP_OTHER;
         if (go_sleep)
            asleep <= 1'b1;
         else if (irq_req || ext_wake)
            asleep <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/adcsl_ctrl_bench.sv
// Self-checking bench for the selection latch and start control
`default_nettype none
`timescale 1ns/1ps
module adcsl_ctrl_bench
   import adcsl_pkg::*;
;
   logic         sys_clk    = 1'b0;
   logic         rst_n      = 1'b0;
   logic         sel_wr     = 1'b0;
   logic         start_wr   = 1'b0;
   logic         done_clr   = 1'b0;
   logic         trigger_in = 1'b0;
   logic         adc_tick   = 1'b0;
   logic         cmp_in     = 1'b0;
   logic         go_sleep   = 1'b0;
   logic         ext_wake   = 1'b0;
   logic         above      = 1'b0;
   logic [2:0]   div        = 3'h0;
   logic [9:0]   vin        = 10'h000;
   adcsl_sel_t   sel_wdata  = ADCSL_SEL_RST;
   adcsl_ctrl_t  ctrl       = 4'h0;
   adcsl_sleep_t mode       = ADCSL_SLP_IDLE;
   adcsl_sleep_t sleep_mode;
   adcsl_sel_t   sel_rdata;
   adcsl_sel_t   sel_active;
   logic [9:0]   dac_code;
   logic [9:0]   result;
   logic         power_on, pre_rst, start_bit, done_flag, irq_req, sleep_conv, cpu_halt, asleep;
   int           n_fail, check_count, cyc;

   adcsl_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .sel_wr(sel_wr), .sel_wdata(sel_wdata),
      .sel_rdata(sel_rdata), .sel_active(sel_active), .ctrl(ctrl), .start_wr(start_wr),
      .done_clr(done_clr), .trigger_in(trigger_in), .adc_tick(adc_tick), .cpu_halt(cpu_halt),
      .sleep_mode(sleep_mode), .cmp_in(cmp_in), .dac_code(dac_code), .analog_power_on(power_on),
      .prescaler_reset(pre_rst), .start_bit(start_bit), .done_flag(done_flag), .result(result),
      .irq_req(irq_req), .sleep_conv(sleep_conv));

   adcsl_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .go_sleep(go_sleep), .mode(mode),
      .ext_wake(ext_wake), .irq_req(irq_req), .cpu_halt(cpu_halt), .sleep_mode(sleep_mode),
      .asleep(asleep));

   always #4 sys_clk = ~sys_clk;

   // Prescaler of eight cycles and an ideal comparator
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      div <= pre_rst ? 3'h0 : div + 3'h1;
      adc_tick <= (div == 3'h7);
      cmp_in <= above || (vin >= dac_code);
      if (cyc == 6000)
      begin
         $display("BAD %0t timeout", $time);
         n_fail++;
         final_report();
      end
   end

   task automatic final_report();
      if (n_fail == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp, input string what);
      chk({9'h0, got}, {9'h0, exp}, what);
   endtask

   task automatic chks(input adcsl_sel_t got, input adcsl_sel_t exp, input string what);
      chk({3'h0, got}, {3'h0, exp}, what);
   endtask

   // One-cycle pulse: 8 start, 4 clear, 2 sleep, 1 wake
   task automatic strobe(input logic [3:0] k);
      @(posedge sys_clk);
      {start_wr, done_clr, go_sleep, ext_wake} <= k;
      @(posedge sys_clk);
      {start_wr, done_clr, go_sleep, ext_wake} <= 4'h0;
   endtask

   task automatic wr_sel(input adcsl_sel_t d);
      @(posedge sys_clk);
      sel_wr <= 1'b1;
      sel_wdata <= d;
      @(posedge sys_clk);
      sel_wr <= 1'b0;
   endtask

   task automatic wait_done();
      int i;
      i = 0;
      // Callers may return on an edge, before a pending clear has landed
      #1;
      while (done_flag !== 1'b1 && i < 400)
      begin
         @(posedge sys_clk);
         #1;
         i++;
      end
      chkb(done_flag, 1'b1, "done wait");
   endtask

   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      chks(sel_active, 7'h00, "latch reset");
      wr_sel(7'h45);
      #1;
      chks(sel_rdata, 7'h45, "buffer read");
      settle();
      chks(sel_active, 7'h45, "latch follows");
      // Single conversion, buffer rewritten one tick after it began
      @(posedge sys_clk);
      ctrl <= 4'h9;
      vin <= 10'h2A5;
      strobe(4'h8);
      #1;
      chkb(start_bit, 1'b1, "start bit");
      @(posedge adc_tick);
      @(posedge adc_tick);
      wr_sel(7'h63);
      settle();
      chks(sel_active, 7'h45, "latch frozen");
      wait_done();
      chk(result, 10'h2A5, "result");
      chkb(start_bit, 1'b0, "start cleared");
      chkb(irq_req, 1'b1, "irq");
      chks(sel_active, 7'h63, "latch reopened");
      // Auto trigger, input above the reference
      strobe(4'h4);
      @(posedge sys_clk);
      ctrl <= 4'hD;
      above <= 1'b1;
      @(posedge sys_clk);
      trigger_in <= 1'b1;
      #1;
      chkb(pre_rst, 1'b1, "prescaler reset");
      wait_done();
      chk(result, 10'h3FF, "full scale");
      // Free running, selection changed after the first result
      @(posedge sys_clk);
      trigger_in <= 1'b0;
      ctrl <= 4'hF;
      above <= 1'b0;
      vin <= 10'h000;
      strobe(4'h4);
      strobe(4'h8);
      wait_done();
      chk(result, 10'h000, "zero code");
      chkb(start_bit, 1'b1, "restart");
      wr_sel(7'h07);
      settle();
      chks(sel_active, 7'h63, "old selection kept");
      strobe(4'h4);
      wait_done();
      chks(sel_active, 7'h07, "new selection");
      @(posedge sys_clk);
      // First result on the new reference is never read
      ctrl <= 4'h0;
      settle();
      chkb(power_on, 1'b0, "power off");
      // Sleep start, early wake by another source
      @(posedge sys_clk);
      ctrl <= 4'h9;
      mode <= ADCSL_SLP_NOISE;
      strobe(4'h4);
      strobe(4'h2);
      settle();
      chkb(sleep_conv, 1'b1, "sleep start");
      chkb(start_bit, 1'b1, "sleep busy");
      strobe(4'h1);
      settle();
      chkb(sleep_conv, 1'b1, "not aborted");
      wait_done();
      chkb(irq_req, 1'b1, "late irq");
      // Sleep start in idle mode, woken by the converter
      @(posedge sys_clk);
      mode <= ADCSL_SLP_IDLE;
      strobe(4'h4);
      strobe(4'h2);
      settle();
      chkb(start_bit, 1'b1, "idle start");
      wait_done();
      settle();
      chkb(asleep, 1'b0, "woken");
      repeat (20) @(posedge sys_clk);
      #1;
      chkb(start_bit, 1'b0, "no restart");
      // Sleep entry while busy
      strobe(4'h4);
      strobe(4'h8);
      strobe(4'h2);
      settle();
      chkb(sleep_conv, 1'b0, "busy sleep ignored");
      wait_done();
      // Other sleep mode leaves the converter alone
      @(posedge sys_clk);
      mode <= ADCSL_SLP_OTHER;
      strobe(4'h4);
      strobe(4'h2);
      settle();
      chkb(start_bit, 1'b0, "other mode");
      chkb(power_on, 1'b1, "still powered");
      final_report();
   end
endmodule
`default_nettype wire
